// ==== cssb_host_model.sv ====
// Purpose: system controller stand-in issuing byte commands
// Assumes: one-cycle command strobe, driven at the falling edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none

module cssb_host_model (
   input  wire logic       i_clock,   // bus clock
   output logic            o_valid,   // command strobe
   output logic            o_write,   // 1 write, 0 read
   output logic [7:0]      o_addr,    // command code
   output logic [7:0]      o_wdata    // write byte
);
   ////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_addr  = 8'h00;
      o_wdata = 8'h00;
   end

   // one command; never acts on the protection bit, fault handling is per register
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_valid = 1'b1;
      o_write = w;
      o_addr  = a;
      o_wdata = d;
      @(negedge i_clock);
      o_valid = 1'b0;
      o_write = ~w;   // stale qualifiers must not be trusted
      o_addr  = ~a;
      o_wdata = ~d;
   endtask
endmodule // cssb_host_model

`default_nettype wire

// ==== cssb_pkg.sv ====
// Purpose: shared constants and carriers for the converter system status bank
// Assumes: one byte per register, byte command codes as offsets
// Notes:   every offset, field position, reset value and timing count lives here
`default_nettype none

package cssb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register command codes
   localparam logic [7:0] CSSB_ADDR_FAULT_OC2   = 8'hda;
   localparam logic [7:0] CSSB_ADDR_SYS_STAT1   = 8'hdc;
   localparam logic [7:0] CSSB_ADDR_SYS_STAT2   = 8'hdd;
   localparam logic [7:0] CSSB_ADDR_SYS_STAT3   = 8'hdf;

   // reset value shared by every register of the bank
   localparam logic [7:0] CSSB_RESET_VALUE      = 8'h00;
   localparam logic [7:0] CSSB_UNMAPPED_VALUE   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // fault register: one overcurrent flag per phase in bits 3:0
   localparam int         CSSB_NUM_PHASES       = 4;
   localparam int         CSSB_OC2_PHASE4_BIT   = 3;

   // system status 1 field positions
   localparam int         CSSB_S1_DIR_BIT       = 0;
   localparam int         CSSB_S1_POS_LSB       = 1;
   localparam int         CSSB_S1_SWMODE_BIT    = 3;
   localparam int         CSSB_S1_PROT_BIT      = 4;
   localparam int         CSSB_S1_OUTSTYLE_BIT  = 5;
   localparam int         CSSB_S1_RSVD_BIT      = 6;
   localparam int         CSSB_S1_READY_BIT     = 7;

   // system status 2 field positions
   localparam int         CSSB_S2_SHED_BIT      = 0;
   localparam int         CSSB_S2_OPCNT_LSB     = 1;
   localparam int         CSSB_S2_MAXCNT_LSB    = 4;
   localparam int         CSSB_S2_RSVD_BIT      = 7;

   // system status 3 field positions
   localparam int         CSSB_S3_CLKSRC_BIT    = 0;
   localparam int         CSSB_S3_LOCK_BIT      = 1;
   localparam int         CSSB_S3_SS_BIT        = 2;
   localparam int         CSSB_S3_SOFTON_BIT    = 3;
   localparam int         CSSB_S3_CHG_BIT       = 4;
   localparam int         CSSB_S3_COMP_BIT      = 5;
   localparam int         CSSB_S3_FPIN_LSB      = 6;

   ////////////////////////////////////////////////////////////////////////////
   // device position codes
   localparam logic [1:0] CSSB_POS_MASTER       = 2'h0;

   // maximum phase count codes
   localparam logic [2:0] CSSB_MAX_FOUR         = 3'h0;
   localparam logic [2:0] CSSB_MAX_THREE        = 3'h2;
   localparam logic [2:0] CSSB_MAX_TWO          = 3'h3;
   localparam logic [2:0] CSSB_MAX_ERROR        = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // startup initialization window before straps are latched
   localparam int         CSSB_CLOCK_HZ         = 25_000_000;
   localparam int         CSSB_INIT_TIME_NS     = 10_000;
   localparam int         CSSB_INIT_CYCLES      = (CSSB_INIT_TIME_NS * (CSSB_CLOCK_HZ / 1_000_000) + 999) / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // pin straps captured once at startup
   typedef struct packed {
      logic [1:0] position;     // device position
      logic       forced_pwm;   // 1 forced pwm, 0 diode_emulation
      logic       hiccup;       // 1 hiccup, 0 latch-off
      logic       three_level;  // 1 three-level pwm outputs
      logic       shed_off;     // phase_shed_strap level
      logic [3:0] pwm_tied;     // pwm pins 4..1 tied high
   } cssb_strap_t;

   // live clock and soft-start state from the timing engine
   typedef struct packed {
      logic       ext_clock;    // external clock in use
      logic       pll_locked;   // pll lock
      logic       ss_done;      // soft-start done
      logic       soft_on_done; // soft-on done
      logic       clk_changed;  // clock source change seen
      logic       comp_short;   // pll compensation short
      logic [1:0] fpin_status;  // frequency_set_pin connection status
   } cssb_clock_t;

   localparam int         CSSB_STRAP_W          = $bits(cssb_strap_t);

endpackage : cssb_pkg

`default_nettype wire

// ==== cssb_status_bank.sv ====
// Purpose: read-only system status bank plus overcurrent flag register
// Assumes: serial bus layer hands over decoded byte commands on i_clock
// Notes:   straps are latched once after the startup initialization window
`timescale 1ns/100ps
`default_nettype none

module cssb_status_bank
   import cssb_pkg::*;
#(
   parameter int INIT_CYCLES = CSSB_INIT_CYCLES
) (
   input  wire logic        i_clock,            // 25 mhz system clock
   input  wire logic        i_reset,            // async reset, high
   // pins, synchronised here
   input  wire logic        i_direction_select_pin, // 1 boost, 0 buck
   input  wire logic [1:0]  i_addr_strap,       // device position strap
   input  wire logic        i_mode_forced_pwm,  // mode strap, switching part
   input  wire logic        i_mode_hiccup,      // mode strap, protection part
   input  wire logic        i_out_style_strap,  // 1 three-level outputs
   input  wire logic        i_phase_shed_strap, // 1 phase drop disabled
   input  wire logic [3:0]  i_pwm_tied_high,    // pwm4..pwm1 tied high
   // same-clock engine signals
   input  wire logic [3:0]  i_second_level_overcurrent, // per-phase event
   input  wire logic        i_pwm_ready,        // pwm engine ready
   input  wire logic [2:0]  i_op_phase_code,    // operating phase code
   input  wire cssb_clock_t i_clock_state,      // clock and soft-start state
   input  wire logic        i_pwm_request,      // engine wants to switch
   // register command port
   input  wire logic        i_cmd_valid,        // command strobe
   input  wire logic        i_cmd_write,        // 1 write, 0 read
   input  wire logic [7:0]  i_cmd_addr,         // command code
   input  wire logic [7:0]  i_cmd_wdata,        // write byte
   output logic      [7:0]  o_rd_data,          // read byte
   output logic             o_rd_valid,         // read answer strobe
   // control outputs
   output logic             o_init_done,        // straps latched
   output logic             o_system_clock_output_en, // clock output gate
   output logic             o_pwm_switch_en,    // switching permitted
   output logic             o_driver_enable_out // driver enable to fets
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   if (INIT_CYCLES < 1) begin : g_bad_init
      $error("INIT_CYCLES must be at least one");
   end
   if (CSSB_NUM_PHASES != 4) begin : g_bad_phases
      $error("bank is laid out for four phases");
   end

   localparam int CNT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic        dir_sync;
   cssb_strap_t strap_raw;
   cssb_strap_t strap_sync;
   cssb_strap_t strap_held;

   // direction pin is live, so it gets its own synchroniser
   cssb_sync #(
      .WIDTH (1)
   ) u_dir_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_async (i_direction_select_pin),
      .o_sync  (dir_sync)
   );

   // gather straps into one carrier before crossing
   always_comb begin
      strap_raw.position    = i_addr_strap;
      strap_raw.forced_pwm  = i_mode_forced_pwm;
      strap_raw.hiccup      = i_mode_hiccup;
      strap_raw.three_level = i_out_style_strap;
      strap_raw.shed_off    = i_phase_shed_strap;
      strap_raw.pwm_tied    = i_pwm_tied_high;
   end

   cssb_sync #(
      .WIDTH (CSSB_STRAP_W)
   ) u_strap_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_async (strap_raw),
      .o_sync  (strap_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // startup initialization window
   typedef enum logic [1:0] {
      CSSB_ST_INIT  = 2'b00,
      CSSB_ST_RUN   = 2'b01
   } cssb_state_t;

   cssb_state_t     state_ff;
   cssb_state_t     nxt_state;
   logic [CNT_W-1:0] init_cnt_ff;
   logic            capture;

   // capture fires on the last init cycle, once per reset
   assign capture = (state_ff == CSSB_ST_INIT) && (init_cnt_ff == INIT_LAST);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CSSB_ST_INIT: begin
            if (capture) begin
               nxt_state = CSSB_ST_RUN;
            end
         end
         CSSB_ST_RUN: begin
            nxt_state = CSSB_ST_RUN;
         end
         default: begin
            nxt_state = CSSB_ST_INIT;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= CSSB_ST_INIT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // init counter, frozen once running
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         init_cnt_ff <= '0;
      end else if (state_ff == CSSB_ST_INIT && !capture) begin
         init_cnt_ff <= init_cnt_ff + CNT_W'(1);
      end
   end

   // straps taken once at the end of the window
   cssb_strap_latch #(
      .WIDTH (CSSB_STRAP_W)
   ) u_strap_latch (
      .i_clock   (i_clock),
      .i_reset   (i_reset),
      .i_capture (capture),
      .i_level   (strap_sync),
      .o_held    (strap_held)
   );

   logic running;
   logic is_master;
   assign running   = (state_ff == CSSB_ST_RUN);
   assign is_master = (strap_held.position == CSSB_POS_MASTER);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_init_done <= 1'b0;
      end else begin
         o_init_done <= running;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overcurrent flag register, sticky, write one to clear
   logic [3:0] oc2_flag_ff;
   logic       oc2_wr;

   assign oc2_wr = i_cmd_valid && i_cmd_write && (i_cmd_addr == CSSB_ADDR_FAULT_OC2);

   // a new event in the clear cycle wins over the clear
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         oc2_flag_ff <= '0;
      end else begin
         oc2_flag_ff <= (oc2_flag_ff & ~(oc2_wr ? i_cmd_wdata[3:0] : 4'h0))
                        | i_second_level_overcurrent;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // maximum phase count decode from tied pwm pins
   logic [2:0] max_code;

   // pwm1 or pwm2 high is a wiring error and outranks the rest
   always_comb begin
      if (strap_held.pwm_tied[0] || strap_held.pwm_tied[1]) begin
         max_code = CSSB_MAX_ERROR;
      end else if (strap_held.pwm_tied[2]) begin
         max_code = CSSB_MAX_TWO;
      end else if (strap_held.pwm_tied[3]) begin
         max_code = CSSB_MAX_THREE;
      end else begin
         max_code = CSSB_MAX_FOUR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status register images, rebuilt every cycle
   logic [7:0] stat1_ff;
   logic [7:0] stat2_ff;
   logic [7:0] stat3_ff;
   logic [7:0] nxt_stat1;
   logic [7:0] nxt_stat2;
   logic [7:0] nxt_stat3;

   // status one: live direction plus latched straps
   always_comb begin
      nxt_stat1 = CSSB_RESET_VALUE;
      if (running) begin
         nxt_stat1[CSSB_S1_DIR_BIT]        = dir_sync;
         nxt_stat1[CSSB_S1_POS_LSB +: 2]   = strap_held.position;
         nxt_stat1[CSSB_S1_SWMODE_BIT]     = strap_held.forced_pwm;
         nxt_stat1[CSSB_S1_PROT_BIT]       = strap_held.hiccup;
         nxt_stat1[CSSB_S1_OUTSTYLE_BIT]   = strap_held.three_level;
         nxt_stat1[CSSB_S1_RSVD_BIT]       = 1'b0;
         nxt_stat1[CSSB_S1_READY_BIT]      = i_pwm_ready && is_master;
      end
   end

   // status two: phase drop, operating and maximum counts
   always_comb begin
      nxt_stat2 = CSSB_RESET_VALUE;
      if (running) begin
         nxt_stat2[CSSB_S2_SHED_BIT]       = strap_held.shed_off
                                             || !is_master;
         nxt_stat2[CSSB_S2_OPCNT_LSB +: 3] = i_op_phase_code;
         nxt_stat2[CSSB_S2_MAXCNT_LSB +: 3] = max_code;
         nxt_stat2[CSSB_S2_RSVD_BIT]       = 1'b0;
      end
   end

   // status three: clock and soft-start state, live
   always_comb begin
      nxt_stat3 = CSSB_RESET_VALUE;
      if (running) begin
         nxt_stat3[CSSB_S3_CLKSRC_BIT]     = i_clock_state.ext_clock;
         nxt_stat3[CSSB_S3_LOCK_BIT]       = i_clock_state.pll_locked;
         nxt_stat3[CSSB_S3_SS_BIT]         = i_clock_state.ss_done;
         nxt_stat3[CSSB_S3_SOFTON_BIT]     = i_clock_state.soft_on_done;
         nxt_stat3[CSSB_S3_CHG_BIT]        = i_clock_state.clk_changed;
         nxt_stat3[CSSB_S3_COMP_BIT]       = i_clock_state.comp_short;
         nxt_stat3[CSSB_S3_FPIN_LSB +: 2]  = i_clock_state.fpin_status;
      end
   end

   // images ignore every host write; only hardware state feeds them
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         stat1_ff <= CSSB_RESET_VALUE;
         stat2_ff <= CSSB_RESET_VALUE;
         stat3_ff <= CSSB_RESET_VALUE;
      end else begin
         stat1_ff <= nxt_stat1;
         stat2_ff <= nxt_stat2;
         stat3_ff <= nxt_stat3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, one cycle after the command strobe
   logic [7:0] nxt_rd_data;

   always_comb begin
      unique case (i_cmd_addr)
         CSSB_ADDR_FAULT_OC2: nxt_rd_data = {4'h0, oc2_flag_ff};
         CSSB_ADDR_SYS_STAT1: nxt_rd_data = stat1_ff;
         CSSB_ADDR_SYS_STAT2: nxt_rd_data = stat2_ff;
         CSSB_ADDR_SYS_STAT3: nxt_rd_data = stat3_ff;
         default:             nxt_rd_data = CSSB_UNMAPPED_VALUE;
      endcase
   end

   // read data holds until the next read answer
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_rd_data  <= CSSB_RESET_VALUE;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_cmd_valid && !i_cmd_write;
         if (i_cmd_valid && !i_cmd_write) begin
            o_rd_data <= nxt_rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock gating of clock output and switching
   // the bank only gates; the engine still decides when to switch
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_system_clock_output_en <= 1'b0;
         o_pwm_switch_en          <= 1'b0;
      end else begin
         o_system_clock_output_en <= running && i_clock_state.pll_locked;
         o_pwm_switch_en          <= running && i_clock_state.pll_locked && i_pwm_request;
      end
   end

   // a slave never drives the driver enable
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_driver_enable_out <= 1'b0;
      end else begin
         o_driver_enable_out <= running && is_master && i_pwm_ready
                                && i_clock_state.pll_locked;
      end
   end

   // protection bit is reported as strapped; per-fault override is software's concern

endmodule // cssb_status_bank

`default_nettype wire

// ==== cssb_status_bank_sva.sv ====
// Purpose: port-level checks of the status bank
// Assumes: single clock domain, async high reset
// Notes:   full image values are left to the bench; timing, reserved-bit, slave-ready and fault-flag rules here
`timescale 1ns/100ps
`default_nettype none

module cssb_status_bank_sva
   import cssb_pkg::*;
(
   input  wire logic        i_clock,                    // system clock
   input  wire logic        i_reset,                    // async reset
   input  wire logic [3:0]  i_second_level_overcurrent, // fault events
   input  wire cssb_clock_t i_clock_state,              // clock state
   input  wire logic        i_pwm_request,              // switch request
   input  wire logic        i_cmd_valid,                // command strobe
   input  wire logic        i_cmd_write,                // write flag
   input  wire logic [7:0]  i_cmd_addr,                 // command code
   input  wire logic [7:0]  o_rd_data,                  // read byte
   input  wire logic        o_rd_valid,                 // read strobe
   input  wire logic        o_init_done,                // straps latched
   input  wire logic        o_system_clock_output_en,   // clock gate
   input  wire logic        o_pwm_switch_en,            // switching gate
   input  wire logic        o_driver_enable_out         // driver enable
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   ////////////////////////////////////////////////////////////////////////////
   // decoded read takes
   logic rd;
   assign rd = i_cmd_valid && !i_cmd_write;

   a_read_answer: assert property (rd |=> o_rd_valid) else $error("read not answered");
   a_no_stray: assert property (!rd |=> !o_rd_valid) else $error("answer without read");
   a_rsvd_one: assert property (rd && i_cmd_addr == CSSB_ADDR_SYS_STAT1 |=> !o_rd_data[6])
      else $error("status one reserved bit set");
   a_rsvd_two: assert property (rd && i_cmd_addr == CSSB_ADDR_SYS_STAT2 |=> !o_rd_data[7])
      else $error("status two reserved bit set");
   a_slave_ready: assert property (rd && i_cmd_addr == CSSB_ADDR_SYS_STAT1
      |=> o_rd_data[2:1] == CSSB_POS_MASTER || !o_rd_data[7]) else $error("slave reports ready");
   a_fault_upper: assert property (rd && i_cmd_addr == CSSB_ADDR_FAULT_OC2 |=> o_rd_data[7:4] == 4'h0)
      else $error("fault upper bits set");
   a_oc_sticky: assert property (i_second_level_overcurrent[3] ##1 !(i_cmd_valid && i_cmd_write)
      ##1 (rd && i_cmd_addr == CSSB_ADDR_FAULT_OC2) |=> o_rd_data[3]) else $error("phase four flag lost");
   a_clk_lock: assert property (!i_clock_state.pll_locked |=> !o_system_clock_output_en && !o_pwm_switch_en)
      else $error("clock or switching without lock");
   a_switch_req: assert property (!i_pwm_request |=> !o_pwm_switch_en) else $error("switching unrequested");
   a_drv_gate: assert property (o_driver_enable_out |-> o_system_clock_output_en)
      else $error("driver enabled without clock");
   a_done_hold: assert property (o_init_done |=> o_init_done) else $error("init done dropped");
endmodule // cssb_status_bank_sva

bind cssb_status_bank cssb_status_bank_sva u_sva (
   .i_clock(i_clock), .i_reset(i_reset), .i_second_level_overcurrent(i_second_level_overcurrent),
   .i_clock_state(i_clock_state), .i_pwm_request(i_pwm_request), .i_cmd_valid(i_cmd_valid),
   .i_cmd_write(i_cmd_write), .i_cmd_addr(i_cmd_addr), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
   .o_init_done(o_init_done), .o_system_clock_output_en(o_system_clock_output_en),
   .o_pwm_switch_en(o_pwm_switch_en), .o_driver_enable_out(o_driver_enable_out));

`default_nettype wire

// ==== cssb_strap_latch.sv ====
// Purpose: one-shot capture of synchronised strap levels
// Assumes: capture strobe comes from the init counter on the same clock
// Notes:   holds the captured value until the next reset
`timescale 1ns/100ps
`default_nettype none

module cssb_strap_latch #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,   // system clock
   input  wire logic             i_reset,   // async reset, high
   input  wire logic             i_capture, // one-cycle capture strobe
   input  wire logic [WIDTH-1:0] i_level,   // synchronised strap levels
   output logic      [WIDTH-1:0] o_held     // latched straps
);

   // straps are caught after release, never inside the reset branch
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_held <= '0;
      end else if (i_capture) begin
         o_held <= i_level;
      end
   end

endmodule // cssb_strap_latch

`default_nettype wire

// ==== cssb_sync.sv ====
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are quasi-static levels
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module cssb_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,   // system clock
   input  wire logic             i_reset,   // async reset, high
   input  wire logic [WIDTH-1:0] i_async,   // pin levels
   output logic      [WIDTH-1:0] o_sync     // synchronised levels
);

   logic [WIDTH-1:0] meta_ff;

   // metastability stage then output stage
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         meta_ff <= '0;
         o_sync  <= '0;
      end else begin
         meta_ff <= i_async;
         o_sync  <= meta_ff;
      end
   end

endmodule // cssb_sync

`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the status bank
// Assumes: short init window, inputs driven at the falling edge
// Notes:   read answers are matched against a queue of notes
`timescale 1ns/100ps
`default_nettype none

module tb;
   import cssb_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        dir = 1'b0, fpwm = 1'b0, hic = 1'b0, sty = 1'b0, shed = 1'b0, rdy = 1'b0, req = 1'b0;
   logic [1:0]  pos = 2'h0, l_pos;
   logic [3:0]  pwm = 4'h0, oc = 4'h0, f, l_pwm;
   logic [2:0]  op = 3'h0;
   cssb_clock_t cs = '0;
   logic        cv, cw, rvalid, done, ckoe, swen, drv, l_f, l_h, l_s, l_sh;
   logic [7:0]  ca, cd, rdata;
   logic [31:0] r;
   logic [7:0]  exp_q[$];
   logic [3:0]  pwm_tab [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'hc};
   int          miscompares = 0;
   int          comparisons = 0;
   int          seed = 45731;

   always #20 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // design and host
   cssb_host_model host (.i_clock(clock), .o_valid(cv), .o_write(cw), .o_addr(ca), .o_wdata(cd));
   cssb_status_bank #(.INIT_CYCLES(8)) dut (
      .i_clock(clock), .i_reset(rst), .i_direction_select_pin(dir), .i_addr_strap(pos),
      .i_mode_forced_pwm(fpwm), .i_mode_hiccup(hic), .i_out_style_strap(sty), .i_phase_shed_strap(shed),
      .i_pwm_tied_high(pwm), .i_second_level_overcurrent(oc), .i_pwm_ready(rdy), .i_op_phase_code(op),
      .i_clock_state(cs), .i_pwm_request(req), .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_addr(ca),
      .i_cmd_wdata(cd), .o_rd_data(rdata), .o_rd_valid(rvalid), .o_init_done(done),
      .o_system_clock_output_en(ckoe), .o_pwm_switch_en(swen), .o_driver_enable_out(drv));

   ////////////////////////////////////////////////////////////////////////////
   // expected images from latched straps and live levels
   function automatic logic [7:0] s1();
      return {rdy & (l_pos == 2'h0), 1'b0, l_s, l_h, l_f, l_pos, dir};
   endfunction
   function automatic logic [7:0] s2();
      logic [2:0] m;
      m = (l_pwm[0] | l_pwm[1]) ? 3'h7 : l_pwm[2] ? 3'h3 : l_pwm[3] ? 3'h2 : 3'h0;
      return {1'b0, m, op, l_sh | (l_pos != 2'h0)};
   endfunction
   function automatic logic [7:0] s3();
      return {cs.fpin_status, cs.comp_short, cs.clk_changed, cs.soft_on_done, cs.ss_done, cs.pll_locked,
              cs.ext_clock};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // note the answer, then issue the read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask
   // new straps under reset; the copies are what must be latched
   task automatic startup(input int k);
      r = $random(seed);
      pos = (k < 2) ? k[1:0] : r[1:0];
      {fpwm, hic, sty, shed} = r[5:2];
      pwm = pwm_tab[k];
      {l_pos, l_f, l_h, l_s, l_sh, l_pwm} = {pos, fpwm, hic, sty, shed, pwm};
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // answer watcher, oldest note first
   always @(negedge clock) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("wrong value at %0t: unexpected answer", $time);
         end else begin
            check(rdata, exp_q.pop_front());
         end
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence: six startups over positions and tied pwm patterns
   initial begin
      for (int k = 0; k < 6; k++) begin
         startup(k);
         rd(CSSB_ADDR_SYS_STAT1, CSSB_RESET_VALUE);
         rd(CSSB_ADDR_SYS_STAT2, CSSB_RESET_VALUE);
         rd(CSSB_ADDR_SYS_STAT3, CSSB_RESET_VALUE);
         repeat (16) @(negedge clock);
         check({7'h0, done}, 8'h01);
         // straps move after the latch, live levels move too
         r = $random(seed);
         {pos, fpwm, hic, sty, shed, pwm} = r[9:0];
         {dir, rdy, req, op} = r[16:11];
         cs = r[24:17];
         cs.fpin_status[0] = cs.fpin_status[0] & ~cs.fpin_status[1];
         repeat (4) @(negedge clock);
         check({7'h0, ckoe}, {7'h0, cs.pll_locked});
         check({7'h0, swen}, {7'h0, cs.pll_locked & req});
         check({7'h0, drv}, {7'h0, cs.pll_locked & rdy & (l_pos == 2'h0)});
         // second pass follows host writes of inverted images
         for (int w = 0; w < 2; w++) begin
            rd(CSSB_ADDR_SYS_STAT1, s1());
            rd(CSSB_ADDR_SYS_STAT2, s2());
            rd(CSSB_ADDR_SYS_STAT3, s3());
            host.xfer(1'b1, CSSB_ADDR_SYS_STAT1, ~s1());
            host.xfer(1'b1, CSSB_ADDR_SYS_STAT2, ~s2());
            host.xfer(1'b1, CSSB_ADDR_SYS_STAT3, ~s3());
         end
         rd(8'hdb, CSSB_UNMAPPED_VALUE);
         rd(CSSB_ADDR_FAULT_OC2, 8'h00);
         // one phase-four event, then a random set, each cleared by ones
         for (int p = 0; p < 2; p++) begin
            f = (p == 0) ? 4'h8 : r[28:25];
            oc = f;
            @(negedge clock);
            oc = 4'h0;
            rd(CSSB_ADDR_FAULT_OC2, {4'h0, f});
            host.xfer(1'b1, CSSB_ADDR_FAULT_OC2, 8'hff);
            rd(CSSB_ADDR_FAULT_OC2, 8'h00);
         end
      end
      repeat (4) @(negedge clock);
      check(8'(exp_q.size()), 8'h00);
      print_verdict();
   end
endmodule // tb

`default_nettype wire
